// ==== rtl/bprs_defines.svh ====
// timing counts, counter widths and board and socket counts for the board power and reset sequencer
`ifndef BPRS_DEFINES_SVH
`define BPRS_DEFINES_SVH

// reference clock rate in Hz
`define BPRS_CLK_HZ          10000000
// delay from clock enable to sequence complete, in ms
`define BPRS_DONE_DELAY_MS   200
// same delay as a count of reference clock cycles
`define BPRS_DONE_DELAY_CYC  ((`BPRS_CLK_HZ / 1000) * `BPRS_DONE_DELAY_MS)
// width of the completion delay counter
`define BPRS_CNT_W           22
// number of board presence interlocks: riser, front panel, storage
`define BPRS_NUM_BOARDS      3
// number of processor sockets
`define BPRS_NUM_CPUS        2
// length of a generated reset pulse, in cycles
`define BPRS_RST_PULSE_CYC   16
`define BPRS_RST_CNT_W       5

`endif

// ==== rtl/bprs_pkg.sv ====
// types shared by the board power and reset sequencer
package bprs_pkg;

  // power sequence steps
  typedef enum logic [3:0] {
    ST_OFF,
    ST_SUPPLY_WAIT,
    ST_RAIL_1V5,
    ST_RAIL_1V2_1V8,
    ST_CPU_POD,
    ST_RAIL_2V5_3V3,
    ST_RAIL_1V25,
    ST_CLOCK_WAIT,
    ST_DONE
  } bprs_state_t;

endpackage

// ==== rtl/bprs_reset_if.sv ====
// reset request and reset output signals between sequencer and reset unit
`timescale 1ns/1ps
interface bprs_reset_if;
  logic power_good;    // sequence complete, level
  logic hard_req;      // hard reset request, pulse
  logic cpu_only_req;  // processor-only hard reset request, pulse
  logic local_req;     // local warm reset request, pulse
  logic binit_req;     // bus-init seen, pulse
  logic soft_req;      // soft reset request, pulse
  logic cpu_rst;       // processors in reset
  logic node_rst;      // node controller in reset
  logic node_cfg_rst;  // node controller configuration cleared
  logic mem_rst;       // memory bus and repeater hub in reset
  logic io_rst;        // io subsystem in reset
  logic lpc_rst;       // north side low-pin-count parts in reset
  logic init_drv;      // drive processor bus init
  logic local_only;    // only local memory reachable

  modport seq (output power_good, hard_req, cpu_only_req, local_req,
               binit_req, soft_req,
               input  cpu_rst, node_rst, node_cfg_rst, mem_rst, io_rst,
               lpc_rst, init_drv, local_only);
  modport rst (input  power_good, hard_req, cpu_only_req, local_req,
               binit_req, soft_req,
               output cpu_rst, node_rst, node_cfg_rst, mem_rst, io_rst,
               lpc_rst, init_drv, local_only);
endinterface

// ==== rtl/bprs_reset_unit.sv ====
// reset distribution: turns reset requests into timed reset pulses
`timescale 1ns/1ps
`include "bprs_defines.svh"
module bprs_reset_unit (
  input  wire logic i_clk,
  input  wire logic i_rstn,
  bprs_reset_if.rst rif
);

  // ------------------------------------------------------------
  // pulse timers, one per reset class
  // ------------------------------------------------------------
  // index: 0 power-good, 1 hard, 2 cpu only, 3 local, 4 binit, 5 soft
  localparam int NR = 6;
  logic [NR-1:0] req;
  logic [NR-1:0] act;
  logic          pg_q;        // previous power-good level
  logic          local_q;     // local memory only after bus init
  wire           pg_rise = rif.power_good & ~pg_q;

  assign req = {rif.soft_req, rif.binit_req, rif.local_req,
                rif.cpu_only_req, rif.hard_req, pg_rise};

  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_tmr
      logic [`BPRS_RST_CNT_W-1:0] cnt_q;
      // a new request restarts the pulse so it is never cut short
      always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
          cnt_q <= '0;
        end else if (req[g]) begin
          cnt_q <= `BPRS_RST_CNT_W'(`BPRS_RST_PULSE_CYC);
        end else if (cnt_q != '0) begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
      assign act[g] = (cnt_q != '0);
    end
  endgenerate

  // ------------------------------------------------------------
  // history of power-good and bus init
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      pg_q    <= 1'b0;
      local_q <= 1'b0;
    end else begin
      pg_q <= rif.power_good;
      // a full reset restores remote access
      if (rif.binit_req) begin
        local_q <= 1'b1;
      end else if (act[0] | act[1]) begin
        local_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // fan out of each reset class to its targets
  // ------------------------------------------------------------
  assign rif.cpu_rst      = act[0] | act[1] | act[2] | act[3];
  assign rif.node_cfg_rst = act[0];
  assign rif.node_rst     = act[0] | act[1] | act[4];
  assign rif.mem_rst      = act[1] | act[3];
  assign rif.io_rst       = act[1];
  assign rif.lpc_rst      = act[3];
  assign rif.init_drv     = act[5];
  assign rif.local_only   = local_q;

endmodule

// ==== rtl/bprs_sequencer.sv ====
// board power-up sequencer with reset distribution
`timescale 1ns/1ps
`include "bprs_defines.svh"
// Operation
// - supply on only when cpu one and interlocks ok
// - interlocks: cpu1, no lone cpu2, three boards
// - main 3.3 V switch stays open until stage
// - power ok: enable 1.5 V, move standby source
// - 1.5 V good enables 1.2 V and 1.8 V
// - both good enable pods and 1.3 V
// - wait for every present pod good
// - then enable 2.5 V and 3.3 V switch
// - 2.5 V and 3.3 V good enable 1.25 V
// - 1.25 V good enables system clocks
// - done output low 200 ms after clocks
// - 1.3 V disable high means enabled
// - each power on gives power good reset
// - hard reset input resets cpus, node, memory, io
// - save bits plus command reset cpus only
// - local reset bit gives warm reset
// - bus init resets node controller only
// - soft reset drives processor bus init
module bprs_sequencer #(
  parameter int DONE_DELAY_CYC = `BPRS_DONE_DELAY_CYC
) (
  input  wire logic                        I_REF_CLK,
  input  wire logic                        I_RSTN,
  input  wire logic                        i_power_on_request_n,
  input  wire logic [`BPRS_NUM_CPUS-1:0]   i_cpu_present_n,
  input  wire logic [`BPRS_NUM_BOARDS-1:0] i_board_present_n,
  input  wire logic                        i_bay_power_ok,
  input  wire logic                        i_rail_1v5_good,
  input  wire logic                        i_rail_1v2_good,
  input  wire logic                        i_rail_1v8_good,
  input  wire logic [`BPRS_NUM_CPUS-1:0]   i_cpu_pod_good,
  input  wire logic                        i_rail_2v5_good,
  input  wire logic                        i_main_3v3_good,
  input  wire logic                        i_rail_1v25_good,
  input  wire logic                        i_hard_reset_in_n,
  input  wire logic                        i_save_config_bit,
  input  wire logic                        i_save_memory_bit,
  input  wire logic                        i_reset_cmd_bit,
  input  wire logic                        i_local_reset_bit,
  input  wire logic                        i_bus_init_n,
  input  wire logic                        i_soft_reset_bit,
  input  wire logic                        i_io_soft_event,
  output logic                             o_supply_on_n,
  output logic                             o_standby_src_main,
  output logic                             o_rail_1v5_en,
  output logic                             o_rail_1v2_en,
  output logic                             o_rail_1v8_en,
  output logic [`BPRS_NUM_CPUS-1:0]        o_cpu_pod_en,
  output logic                             o_rail_1v3_disable,
  output logic                             o_rail_2v5_en,
  output logic                             o_main_3v3_switch_en_n,
  output logic                             o_rail_1v25_en,
  output logic                             o_system_clock_en,
  output logic                             o_sequence_done_n,
  output logic                             o_cpu_reset,
  output logic                             o_node_reset,
  output logic                             o_node_cfg_clear,
  output logic                             o_mem_reset,
  output logic                             o_io_reset,
  output logic                             o_lpc_reset,
  output logic                             o_bus_init_drive,
  output logic                             o_local_mem_only
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // pins from other boards or supplies get two flops each; i_io_soft_event is used unsynchronised
  localparam int NS = 22;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] meta_q;   // first stage, read only by sync_q
  logic [NS-1:0] sync_q;   // second stage, safe to use

  assign pin_raw = {i_power_on_request_n, i_cpu_present_n,
                    i_board_present_n, i_bay_power_ok, i_rail_1v5_good,
                    i_rail_1v2_good, i_rail_1v8_good, i_cpu_pod_good,
                    i_rail_2v5_good, i_main_3v3_good, i_rail_1v25_good,
                    i_hard_reset_in_n, i_save_config_bit,
                    i_save_memory_bit, i_reset_cmd_bit,
                    i_local_reset_bit, i_bus_init_n, i_soft_reset_bit};

  // two stage synchroniser for every pin except i_io_soft_event
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      // idle pin levels, so no edge detector sees a false edge
      meta_q <= 22'h3f0042;
      sync_q <= 22'h3f0042;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  // named views of the synchronised pins and of the raw i_io_soft_event
  wire                        s_req_n    = sync_q[21];
  wire [`BPRS_NUM_CPUS-1:0]   s_cpu_n    = sync_q[20:19];
  wire [`BPRS_NUM_BOARDS-1:0] s_board_n  = sync_q[18:16];
  wire                        s_pwok     = sync_q[15];
  wire                        s_1v5      = sync_q[14];
  wire                        s_1v2      = sync_q[13];
  wire                        s_1v8      = sync_q[12];
  wire [`BPRS_NUM_CPUS-1:0]   s_pod      = sync_q[11:10];
  wire                        s_2v5      = sync_q[9];
  wire                        s_3v3      = sync_q[8];
  wire                        s_1v25     = sync_q[7];
  wire                        s_hard_n   = sync_q[6];
  wire                        s_save_config_bit   = sync_q[5];
  wire                        s_save_memory_bit   = sync_q[4];
  wire                        s_rcmd     = sync_q[3];
  wire                        s_local    = sync_q[2];
  wire                        s_binit_n  = sync_q[1];
  wire                        s_soft     = sync_q[0];
  wire                        s_io_soft  = i_io_soft_event;

  // ------------------------------------------------------------
  // interlock and pod qualification
  // ------------------------------------------------------------
  wire cpu1_ok     = ~s_cpu_n[0];
  wire cpu2_ok     = s_cpu_n[1] | ~s_cpu_n[0];
  wire boards_ok   = ~|s_board_n;
  wire interlock_ok = cpu1_ok & cpu2_ok & boards_ok;
  // absent sockets count as good so one cpu boards still advance
  wire pods_ok     = &(s_pod | s_cpu_n);
  wire request     = ~s_req_n;

  // ------------------------------------------------------------
  // sequence state machine
  // ------------------------------------------------------------
  bprs_pkg::bprs_state_t state_q;
  bprs_pkg::bprs_state_t state_d;
  logic [`BPRS_CNT_W-1:0] dly_q;       // completion delay counter
  wire                    dly_end = (dly_q >= `BPRS_CNT_W'(DONE_DELAY_CYC - 1));

  // next step; dropping the request powers down, a lost power ok returns to ST_SUPPLY_WAIT
  always_comb begin
    state_d = state_q;
    if (!request) begin
      state_d = bprs_pkg::ST_OFF;
    end else begin
      case (state_q)
        bprs_pkg::ST_OFF: begin
          if (interlock_ok) state_d = bprs_pkg::ST_SUPPLY_WAIT;
        end
        bprs_pkg::ST_SUPPLY_WAIT: begin
          if (s_pwok) state_d = bprs_pkg::ST_RAIL_1V5;
        end
        bprs_pkg::ST_RAIL_1V5: begin
          if (s_1v5) state_d = bprs_pkg::ST_RAIL_1V2_1V8;
        end
        bprs_pkg::ST_RAIL_1V2_1V8: begin
          if (s_1v2 && s_1v8) state_d = bprs_pkg::ST_CPU_POD;
        end
        bprs_pkg::ST_CPU_POD: begin
          if (pods_ok) state_d = bprs_pkg::ST_RAIL_2V5_3V3;
        end
        bprs_pkg::ST_RAIL_2V5_3V3: begin
          if (s_2v5 && s_3v3) state_d = bprs_pkg::ST_RAIL_1V25;
        end
        bprs_pkg::ST_RAIL_1V25: begin
          if (s_1v25) state_d = bprs_pkg::ST_CLOCK_WAIT;
        end
        bprs_pkg::ST_CLOCK_WAIT: begin
          if (dly_end) state_d = bprs_pkg::ST_DONE;
        end
        bprs_pkg::ST_DONE: begin
          state_d = bprs_pkg::ST_DONE;
        end
        default: begin
          state_d = bprs_pkg::ST_OFF;
        end
      endcase
      // losing main power after supplies came on restarts the sequence
      if (state_q > bprs_pkg::ST_SUPPLY_WAIT && !s_pwok) begin
        state_d = bprs_pkg::ST_SUPPLY_WAIT;
      end
    end
  end

  // state register and the clock-to-done delay counter
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      state_q <= bprs_pkg::ST_OFF;
      dly_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q == bprs_pkg::ST_CLOCK_WAIT && !dly_end) begin
        dly_q <= dly_q + 1'b1;
      end else if (state_q != bprs_pkg::ST_CLOCK_WAIT) begin
        dly_q <= '0;
      end
    end
  end

  // ------------------------------------------------------------
  // stage decode for the enable outputs
  // ------------------------------------------------------------
  wire at_supply = (state_d >= bprs_pkg::ST_SUPPLY_WAIT);
  wire at_1v5    = (state_d >= bprs_pkg::ST_RAIL_1V5);
  wire at_1v2    = (state_d >= bprs_pkg::ST_RAIL_1V2_1V8);
  wire at_pod    = (state_d >= bprs_pkg::ST_CPU_POD);
  wire at_2v5    = (state_d >= bprs_pkg::ST_RAIL_2V5_3V3);
  wire at_1v25   = (state_d >= bprs_pkg::ST_RAIL_1V25);
  wire at_clk    = (state_d >= bprs_pkg::ST_CLOCK_WAIT);
  wire at_done   = (state_d == bprs_pkg::ST_DONE);

  // ------------------------------------------------------------
  // reset request edges
  // ------------------------------------------------------------
  logic hard_q, cpu_cmd_q, local_q, binit_q, soft_q;
  wire  cpu_cmd = s_save_config_bit & s_save_memory_bit & s_rcmd;
  wire  soft_any = s_soft | s_io_soft;

  bprs_reset_if rif ();

  // taken from the next state so the pulse meets the held reset gap free
  assign rif.power_good   = at_done;
  assign rif.hard_req     = ~s_hard_n & hard_q;
  assign rif.cpu_only_req = cpu_cmd & ~cpu_cmd_q;
  assign rif.local_req    = s_local & ~local_q;
  assign rif.binit_req    = ~s_binit_n & binit_q;
  assign rif.soft_req     = soft_any & ~soft_q;

  // previous levels for the request edge detectors
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      hard_q    <= 1'b1;
      cpu_cmd_q <= 1'b0;
      local_q   <= 1'b0;
      binit_q   <= 1'b1;
      soft_q    <= 1'b0;
    end else begin
      hard_q    <= s_hard_n;
      cpu_cmd_q <= cpu_cmd;
      local_q   <= s_local;
      binit_q   <= s_binit_n;
      soft_q    <= soft_any;
    end
  end

  bprs_reset_unit u_reset (
    .i_clk  (I_REF_CLK),
    .i_rstn (I_RSTN),
    .rif    (rif)
  );

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  // every output is a flop; power outputs default to the safe off level
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      o_supply_on_n          <= 1'b1;
      o_standby_src_main     <= 1'b0;
      o_rail_1v5_en          <= 1'b0;
      o_rail_1v2_en          <= 1'b0;
      o_rail_1v8_en          <= 1'b0;
      o_cpu_pod_en           <= '0;
      o_rail_1v3_disable     <= 1'b0;
      o_rail_2v5_en          <= 1'b0;
      o_main_3v3_switch_en_n <= 1'b1;
      o_rail_1v25_en         <= 1'b0;
      o_system_clock_en      <= 1'b0;
      o_sequence_done_n      <= 1'b1;
    end else begin
      o_supply_on_n          <= ~at_supply;
      o_standby_src_main     <= at_1v5;
      o_rail_1v5_en          <= at_1v5;
      o_rail_1v2_en          <= at_1v2;
      o_rail_1v8_en          <= at_1v2;
      // only fitted processors get pod power
      o_cpu_pod_en           <= at_pod ? ~s_cpu_n : '0;
      // high level keeps 1.3 V running, low shuts it off
      o_rail_1v3_disable     <= at_pod;
      o_rail_2v5_en          <= at_2v5;
      o_main_3v3_switch_en_n <= ~at_2v5;
      o_rail_1v25_en         <= at_1v25;
      o_system_clock_en      <= at_clk;
      o_sequence_done_n      <= ~at_done;
    end
  end

  // reset fan-out registered to the pins
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RSTN) begin
      o_cpu_reset      <= 1'b1;
      o_node_reset     <= 1'b1;
      o_node_cfg_clear <= 1'b1;
      o_mem_reset      <= 1'b1;
      o_io_reset       <= 1'b1;
      o_lpc_reset      <= 1'b1;
      o_bus_init_drive <= 1'b0;
      o_local_mem_only <= 1'b0;
    end else begin
      // hold cpu, node, config, memory, io and lpc resets until the sequence is complete
      o_cpu_reset      <= rif.cpu_rst | o_sequence_done_n;
      o_node_reset     <= rif.node_rst | o_sequence_done_n;
      o_node_cfg_clear <= rif.node_cfg_rst | o_sequence_done_n;
      o_mem_reset      <= rif.mem_rst | o_sequence_done_n;
      o_io_reset       <= rif.io_rst | o_sequence_done_n;
      o_lpc_reset      <= rif.lpc_rst | o_sequence_done_n;
      o_bus_init_drive <= rif.init_drv;
      o_local_mem_only <= rif.local_only;
    end
  end

endmodule

// ==== test/bprs_seq_asserts.sv ====
// concurrent checks on the ports of the board power and reset sequencer
`timescale 1ns/1ps
module bprs_seq_asserts #(
  parameter int DONE_DELAY_CYC = 20
) (
  input wire logic       I_REF_CLK,
  input wire logic       I_RSTN,
  input wire logic [1:0] i_cpu_present_n,
  input wire logic [2:0] i_board_present_n,
  input wire logic       i_bay_power_ok,
  input wire logic       i_rail_1v5_good,
  input wire logic       i_rail_1v2_good,
  input wire logic       i_rail_1v8_good,
  input wire logic [1:0] i_cpu_pod_good,
  input wire logic       i_rail_2v5_good,
  input wire logic       i_main_3v3_good,
  input wire logic       i_rail_1v25_good,
  input wire logic       i_hard_reset_in_n,
  input wire logic       o_supply_on_n,
  input wire logic       o_standby_src_main,
  input wire logic       o_rail_1v5_en,
  input wire logic       o_rail_1v2_en,
  input wire logic       o_rail_1v3_disable,
  input wire logic       o_rail_2v5_en,
  input wire logic       o_main_3v3_switch_en_n,
  input wire logic       o_rail_1v25_en,
  input wire logic       o_system_clock_en,
  input wire logic       o_sequence_done_n,
  input wire logic       o_cpu_reset,
  input wire logic       o_node_reset,
  input wire logic       o_node_cfg_clear,
  input wire logic       o_mem_reset,
  input wire logic       o_io_reset
);
  // slack around the completion delay, the sync stages add a few cycles
  localparam int DLO = DONE_DELAY_CYC - 2;
  localparam int DHI = DONE_DELAY_CYC + 4;
  // cpu one fitted and every board fitted
  wire ilk_ok  = !i_cpu_present_n[0] && (i_board_present_n == 3'h0);
  // absent sockets count as good
  wire pods_ok = &(i_cpu_pod_good | i_cpu_present_n);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);
  sequence s_clk_up;
    $rose(o_system_clock_en);
  endsequence
  sequence s_done;
    $fell(o_sequence_done_n);
  endsequence
  AST_SUPPLY_GATE: assert property (
    $fell(o_supply_on_n) |-> $past(ilk_ok, 2))
    else $error("supplies on with an interlock open");
  AST_SWITCH_HELD: assert property (
    o_rail_2v5_en == !o_main_3v3_switch_en_n)
    else $error("3v3 switch and 2v5 enable disagree");
  AST_RAIL_1V5: assert property (
    $rose(o_rail_1v5_en) |-> o_standby_src_main && $past(i_bay_power_ok, 2))
    else $error("1v5 enabled without bay ok");
  AST_RAIL_1V2: assert property (
    $rose(o_rail_1v2_en) |-> o_rail_1v5_en && $past(i_rail_1v5_good, 2))
    else $error("1v2 enabled without 1v5 good");
  AST_POD_STAGE: assert property (
    $rose(o_rail_1v3_disable) |->
      $past(i_rail_1v2_good && i_rail_1v8_good, 2) && o_rail_1v2_en)
    else $error("pods enabled without 1v2 and 1v8 good");
  AST_POD_WAIT: assert property (
    $rose(o_rail_2v5_en) |-> $past(pods_ok, 2) && o_rail_1v3_disable)
    else $error("advanced past pods before all pods good");
  AST_RAIL_1V25: assert property (
    $rose(o_rail_1v25_en) |-> $past(i_rail_2v5_good && i_main_3v3_good, 2))
    else $error("1v25 enabled before 2v5 and 3v3 good");
  AST_CLK_EN: assert property (
    s_clk_up |-> $past(i_rail_1v25_good, 2) && o_rail_1v25_en)
    else $error("clocks enabled before 1v25 good");
  AST_DONE_LATE: assert property (
    s_clk_up |-> ##[DLO:DHI] !o_sequence_done_n)
    else $error("sequence done not reported in time");
  AST_DONE_EARLY: assert property (
    s_done |-> $past(o_system_clock_en, DLO))
    else $error("sequence done reported too early");
  AST_PG_RESET: assert property (
    s_done |-> ##8 (o_cpu_reset && o_node_reset && o_node_cfg_clear))
    else $error("no power good reset after power on");
  AST_HARD: assert property (
    $fell(i_hard_reset_in_n) |->
      ##[2:6] (o_cpu_reset && o_node_reset && o_mem_reset && o_io_reset))
    else $error("hard reset input not obeyed");
endmodule
bind bprs_sequencer bprs_seq_asserts #(
  .DONE_DELAY_CYC(DONE_DELAY_CYC)
) i_seq_asserts (.*);

// ==== test/bprs_rail_model.sv ====
// supply bay and converter model facing the sequencer
`timescale 1ns/1ps
module bprs_rail_model (
  input  wire logic       i_clk,
  input  wire logic       i_slow,  // long ramp on every rail
  input  wire logic [8:0] i_en,    // bit0 bay, others converters
  input  wire logic [8:0] i_hold,  // keeps a good low, for faults
  output logic      [8:0] o_good
);
  logic [4:0] ramp_q [9];  // cycles since enable, saturating
  // a disabled rail loses its good at the next clock, no stale level
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 9; k++) begin
      if (!i_en[k] || i_hold[k]) begin
        ramp_q[k] <= 5'h00;
      end else if (ramp_q[k] != 5'h1f) begin
        ramp_q[k] <= ramp_q[k] + 5'h01;
      end
    end
  end
  // good, bay ok included, only after the ramp
  always_comb begin
    for (int k = 0; k < 9; k++) begin
      o_good[k] = ramp_q[k] >= (i_slow ? 5'h0c : 5'h02);
    end
  end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the board power and reset sequencer
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] MSK [6] = '{8'h01, 8'h0e, 8'h10, 8'h20, 8'h40,
                                     8'h80};  // trigger per reset kind
  localparam logic [7:0] REXP [6] = '{8'hd8, 8'h80, 8'h94, 8'h41, 8'h03,
                                      8'h03};  // resets seen per kind
  logic        ref_clk, rstn, req_n, slow, rst_on;
  logic [1:0]  cpu_n;
  logic [2:0]  brd_n;
  logic [7:0]  trg;              // reset event inputs
  logic [8:0]  hold, good;
  logic [12:0] pwr, last;        // power outputs, last seen
  logic [7:0]  rst;              // reset outputs
  logic [6:0]  prv;
  logic [31:0] seed = 32'h31;    // start value 49
  logic [12:0] pwr_q [$];
  logic [7:0]  rst_q [$];
  int          n_fail, compares;
  wire  [8:0]  rail_en = {pwr[2], !pwr[3], pwr[4], pwr[7:6], pwr[8],
                          pwr[9], pwr[10], !pwr[12]};
  bprs_sequencer #(.DONE_DELAY_CYC(20)) i_dut (
    .I_REF_CLK(ref_clk), .I_RSTN(rstn), .i_power_on_request_n(req_n),
    .i_cpu_present_n(cpu_n), .i_board_present_n(brd_n),
    .i_bay_power_ok(good[0]), .i_rail_1v5_good(good[1]),
    .i_rail_1v2_good(good[2]), .i_rail_1v8_good(good[3]),
    .i_cpu_pod_good(good[5:4]), .i_rail_2v5_good(good[6]),
    .i_main_3v3_good(good[7]), .i_rail_1v25_good(good[8]),
    .i_hard_reset_in_n(!trg[0]), .i_save_config_bit(trg[1]),
    .i_save_memory_bit(trg[2]), .i_reset_cmd_bit(trg[3]),
    .i_local_reset_bit(trg[4]), .i_bus_init_n(!trg[5]),
    .i_soft_reset_bit(trg[6]), .i_io_soft_event(trg[7]),
    .o_supply_on_n(pwr[12]), .o_standby_src_main(pwr[11]),
    .o_rail_1v5_en(pwr[10]), .o_rail_1v2_en(pwr[9]),
    .o_rail_1v8_en(pwr[8]), .o_cpu_pod_en(pwr[7:6]),
    .o_rail_1v3_disable(pwr[5]), .o_rail_2v5_en(pwr[4]),
    .o_main_3v3_switch_en_n(pwr[3]), .o_rail_1v25_en(pwr[2]),
    .o_system_clock_en(pwr[1]), .o_sequence_done_n(pwr[0]),
    .o_cpu_reset(rst[7]), .o_node_reset(rst[6]), .o_node_cfg_clear(rst[5]),
    .o_mem_reset(rst[4]), .o_io_reset(rst[3]), .o_lpc_reset(rst[2]),
    .o_bus_init_drive(rst[1]), .o_local_mem_only(rst[0]));
  bprs_rail_model i_rails (.i_clk(ref_clk), .i_slow(slow), .i_en(rail_en),
                           .i_hold(hold), .o_good(good));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // power outputs expected at sequence stage n
  function automatic logic [12:0] pexp(int n, logic [1:0] p);
    pexp = {n < 1, n >= 2, n >= 2, n >= 3, n >= 3, (n >= 4) ? p : 2'h0,
            n >= 4, n >= 5, n < 5, n >= 6, n >= 7, n < 8};
  endfunction
  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed[2:0]);
  endfunction
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic stall(string what);
    n_fail++;
    $display("unexpected %s expected progress seen timeout", what);
    end_of_test();
  endtask
  task automatic cmp_pwr(logic [12:0] e, logic [12:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected power_outputs expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_rst(logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected reset_outputs expected %h seen %h", e, s);
    end
  endtask
  // note stages a..b as the expected order of power changes
  task automatic run(int a, int b, logic [1:0] p);
    for (int n = a; n <= b; n++) pwr_q.push_back(pexp(n, p));
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 400 && pwr_q.size() > 0; k++) step();
    if (pwr_q.size() > 0) stall("power_sequence");
  endtask
  task automatic quiet();
    int k;
    for (k = 0; k < 80 && rst[7:1] !== 7'h00; k++) step();
    if (rst[7:1] !== 7'h00) stall("reset_release");
  endtask
  // every change of the power outputs must be the next noted stage
  always @(negedge ref_clk) begin
    if (!rstn) begin
      last = pexp(0, 2'h0);
    end else if (pwr !== last) begin
      cmp_pwr(pwr_q.size() ? pwr_q.pop_front() : last, pwr);
      last = pwr;
    end
  end
  // a reset pulse, once settled, must match the noted kind
  always @(negedge ref_clk) begin
    if (rst_on && rst[7:1] !== 7'h00 && prv === 7'h00) begin
      repeat (3) @(negedge ref_clk);
      cmp_rst(rst_q.size() ? rst_q.pop_front() : 8'h00, rst);
    end
    prv = rst[7:1];
  end
  initial begin
    rstn = 1'b0;
    req_n = 1'b1;
    slow = 1'b0;
    rst_on = 1'b0;
    cpu_n = 2'h2;
    brd_n = 3'h0;
    trg = 8'h00;
    hold = 9'h000;
    n_fail = 0;
    compares = 0;
    step(5);
    rstn = 1'b1;
    // each failing interlock: request must leave everything off
    for (int k = 0; k < 4; k++) begin
      cpu_n = (k == 0) ? 2'h1 : 2'h2;
      brd_n = (k == 0) ? 3'h0 : 3'h1 << (k - 1);
      step(2);
      req_n = 1'b0;
      step(12);
      req_n = 1'b1;
      step(4);
    end
    brd_n = 3'h0;
    step(4);
    run(1, 8, 2'h1);
    req_n = 1'b0;
    drain();
    quiet();
    rst_on = 1'b1;
    for (int k = 0; k < 7; k++) begin
      rst_q.push_back(REXP[k % 6]);
      if (k % 6 == 1) begin
        trg = 8'h06;
        step();
      end
      trg = MSK[k % 6];
      step(2 + rnd());
      trg = 8'h00;
      step(6);
      quiet();
      step(4);
    end
    rst_on = 1'b0;
    run(0, 0, 2'h0);
    req_n = 1'b1;
    drain();
    // both cpus, slow rails, second pod late: must wait at pods
    cpu_n = 2'h0;
    slow = 1'b1;
    hold = 9'h020;
    step(4);
    run(1, 4, 2'h3);
    req_n = 1'b0;
    drain();
    step(30);
    run(5, 8, 2'h3);
    hold = 9'h000;
    drain();
    quiet();
    // bay ok lost after completion, then restored
    run(1, 1, 2'h3);
    hold = 9'h001;
    drain();
    run(2, 8, 2'h3);
    hold = 9'h000;
    drain();
    quiet();
    end_of_test();
  end
endmodule
